// file: logic/ppl_loader.sv
// Parallel programming port: command, address, page buffers and nonvolatile bytes
//
// How it works
// R1 - Address action with byte selects 01 loads address bits 15 to 8.
// R2 - Address action with byte selects 10 loads extended address bits 23 to 16.
// R3 - Write strobe low, selects 00, flash command: program page, ready goes low.
// R4 - Programmer waits for ready high before the next page.
// R5 - No operation command clears the internal write state.
// R6 - Programmer loads EEPROM command, addresses and data, latching each byte.
// R7 - Write strobe low, selects 00, EEPROM command: program EEPROM page, busy.
// R8 - Flash read drives low byte for select one 0, high byte for 1.
// R9 - EEPROM read drives addressed byte when select one is 0.
// R10 - Fuse write stores low data byte; zero programs, one erases; busy follows.
// R11 - Selects 01 at write strobe target the high fuse byte.
// R12 - Selects 10 at write strobe target the extended fuse byte.
// R13 - Lock write programs lock bits where the data bit is zero.
// R14 - In lock mode 3 boot lock bits cannot be programmed.
// R15 - Lock write never erases a lock bit.
// R16 - Fuse read: 00 low, 11 high, 10 extended, 01 lock byte.
// R17 - Signature read drives identification byte for address 0 to 2.
// R18 - Signature read with select one high at address 0 gives calibration.
// R19 - Programmer repeats address, data, latch and page write per page.
// R20 - Action select: 00 address, 01 data, 10 command, 11 idle.
// R21 - Page latch rising edge stores loaded data at the current word address.
// R22 - Data bus drive follows output enable low, registered one clock late.
// R23 - Ready stays high whenever no write is in progress.
// R24 - Command and address bytes are held until overwritten.
`timescale 1ns/1ps
module ppl_loader #(
    parameter int         FLASH_AW     = ppl_pkg::FLASH_AW,
    parameter int         FPAGE_AW     = ppl_pkg::FPAGE_AW,
    parameter int         EE_AW        = ppl_pkg::EE_AW,
    parameter int         EPAGE_AW     = ppl_pkg::EPAGE_AW,
    parameter int         WRITE_CYCLES = ppl_pkg::WRITE_CYCLES,
    // Identification values below are arbitrary
    parameter logic [7:0] ID_BYTE0     = 8'h5a,
    parameter logic [7:0] ID_BYTE1     = 8'h3c,
    parameter logic [7:0] ID_BYTE2     = 8'h0f,
    parameter logic [7:0] CAL_BYTE     = 8'h80
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Programmer control lines
    input  wire logic       load_strobe,
    input  wire logic       action_select_hi,
    input  wire logic       action_select_lo,
    input  wire logic       byte_select_one,
    input  wire logic       byte_select_two,
    input  wire logic       page_latch_strobe,
    input  wire logic       write_n,
    input  wire logic       output_enable_n,
    // Bidirectional data bus
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // Status
    output logic            ready_busy_flag
);

    localparam int CW = FPAGE_AW + 1;
    localparam int BW = $clog2(WRITE_CYCLES + 1);
    localparam logic [CW-1:0] FLASH_LIMIT = CW'(1 << FPAGE_AW);
    localparam logic [CW-1:0] EE_LIMIT    = CW'(1 << EPAGE_AW);
    localparam logic [BW-1:0] BUSY_LAST   = BW'(WRITE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic upper);
        pick_byte = upper ? word[15:8] : word[7:0];
    endfunction

    // Busy timer stops at its last count
    function automatic logic [BW-1:0] sat_inc(input logic [BW-1:0] cnt);
        sat_inc = (cnt == BUSY_LAST) ? cnt : cnt + 1'b1;
    endfunction

    // Lock bits only ever go from 1 to 0; boot bits freeze in mode 3
    function automatic logic [7:0] lock_merge(input logic [7:0] old, input logic [7:0] req);
        logic [7:0] frozen;
        frozen = '0;
        if ({old[ppl_pkg::LOCK_SECOND_BIT], old[ppl_pkg::LOCK_FIRST_BIT]} == ppl_pkg::LOCK_MODE3)
        begin
            frozen = ppl_pkg::LOCK_BOOT_MASK;                                   // [R14]
        end
        lock_merge = old & (req | frozen);                                      // [R13] [R15]
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    ppl_pkg::ppl_state_t    state;
    ppl_pkg::ppl_state_t    next_state;
    logic [CW-1:0]          copy_cnt;
    logic [CW-1:0]          next_copy_cnt;
    logic [BW-1:0]          busy_cnt;
    logic [BW-1:0]          next_busy_cnt;
    logic                   copy_ee;
    logic                   next_copy_ee;

    // Pin history; reset to idle levels so reset makes no false edge
    logic                   load_prev;
    logic                   latch_prev;
    logic                   write_n_prev;
    logic                   next_load_prev;
    logic                   next_latch_prev;
    logic                   next_write_n_prev;

    // Loaded bytes
    logic [7:0]             cmd;
    logic [7:0]             addr_lo;
    logic [7:0]             addr_hi;
    logic [7:0]             addr_ext;
    logic [7:0]             data_lo;
    logic [7:0]             data_hi;
    logic [7:0]             next_cmd;
    logic [7:0]             next_addr_lo;
    logic [7:0]             next_addr_hi;
    logic [7:0]             next_addr_ext;
    logic [7:0]             next_data_lo;
    logic [7:0]             next_data_hi;

    // Nonvolatile bytes and read port
    logic [7:0]             fuse_low;
    logic [7:0]             fuse_high;
    logic [7:0]             fuse_ext;
    logic [7:0]             lock;
    logic [7:0]             next_fuse_low;
    logic [7:0]             next_fuse_high;
    logic [7:0]             next_fuse_ext;
    logic [7:0]             next_lock;
    logic [7:0]             next_data_out;
    logic                   next_data_oe;

    // Decoded strobes
    logic [1:0]             act;
    logic [1:0]             sel;
    logic                   idle;
    logic                   load_evt;
    logic                   latch_evt;
    logic                   write_evt;
    logic                   start_page;
    logic                   start_nv;
    logic [23:0]            full_addr;
    logic [CW-1:0]          copy_idx;
    logic [CW-1:0]          copy_limit;

    // Memory ports
    logic                   fbuf_we;
    logic [FPAGE_AW-1:0]    fbuf_raddr;
    logic [15:0]            fbuf_rdata;
    logic                   ebuf_we;
    logic [EPAGE_AW-1:0]    ebuf_raddr;
    logic [7:0]             ebuf_rdata;
    logic                   flash_we;
    logic [FLASH_AW-1:0]    flash_waddr;
    logic [15:0]            flash_rdata;
    logic                   ee_we;
    logic [EE_AW-1:0]       ee_waddr;
    logic [7:0]             ee_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decoding

    assign act        = {action_select_hi, action_select_lo};
    assign sel        = {byte_select_two, byte_select_one};
    assign idle       = (state == ppl_pkg::PPL_IDLE);
    // Strobes are ignored while busy, so the page address cannot move under a copy
    assign load_evt   = idle && rise(load_strobe, load_prev);
    assign latch_evt  = idle && rise(page_latch_strobe, latch_prev);
    assign write_evt  = idle && rise(write_n_prev, write_n);
    assign start_page = write_evt && (sel == ppl_pkg::SEL_LOW)                         // [R3] [R7]
                        && (cmd == ppl_pkg::CMD_WR_FLASH || cmd == ppl_pkg::CMD_WR_EE);
    assign start_nv   = write_evt && (cmd == ppl_pkg::CMD_WR_FUSE || cmd == ppl_pkg::CMD_WR_LOCK);
    assign full_addr  = {addr_ext, addr_hi, addr_lo};
    assign copy_idx   = copy_cnt - 1'b1;
    assign copy_limit = copy_ee ? EE_LIMIT : FLASH_LIMIT;
    assign ready_busy_flag = idle;                                                   // [R23]

    always_comb
    begin
        next_load_prev    = load_strobe;
        next_latch_prev   = page_latch_strobe;
        next_write_n_prev = write_n;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            load_prev    <= 1'b0;
            latch_prev   <= 1'b0;
            write_n_prev <= 1'b1;
        end
        else
        begin
            load_prev    <= next_load_prev;
            latch_prev   <= next_latch_prev;
            write_n_prev <= next_write_n_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command, address and data loading

    always_comb
    begin
        next_cmd      = cmd;
        next_addr_lo  = addr_lo;
        next_addr_hi  = addr_hi;
        next_addr_ext = addr_ext;
        next_data_lo  = data_lo;
        next_data_hi  = data_hi;
        // Action 11 falls through: nothing is loaded [R20]
        if (load_evt)
        begin
            if (act == ppl_pkg::ACT_CMD)
                next_cmd = data_in;                                                 // [R20] [R5]
            else if (act == ppl_pkg::ACT_DATA && byte_select_one)
                next_data_hi = data_in;                                             // [R20]
            else if (act == ppl_pkg::ACT_DATA)
                next_data_lo = data_in;                                             // [R20]
            else if (act == ppl_pkg::ACT_ADDR && sel == ppl_pkg::SEL_LOW)
                next_addr_lo = data_in;                                             // [R20]
            else if (act == ppl_pkg::ACT_ADDR && sel == ppl_pkg::SEL_HIGH)
                next_addr_hi = data_in;                                             // [R1]
            else if (act == ppl_pkg::ACT_ADDR && sel == ppl_pkg::SEL_EXT)
                next_addr_ext = data_in;                                            // [R2]
        end
    end

    // Held until the next load overwrites them
    always_ff @(posedge core_clk or negedge nrst)                                    // [R24]
    begin
        if (!nrst)
        begin
            cmd      <= ppl_pkg::CMD_NOP;
            addr_lo  <= '0;
            addr_hi  <= '0;
            addr_ext <= '0;
            data_lo  <= '0;
            data_hi  <= '0;
        end
        else
        begin
            cmd      <= next_cmd;
            addr_lo  <= next_addr_lo;
            addr_hi  <= next_addr_hi;
            addr_ext <= next_addr_ext;
            data_lo  <= next_data_lo;
            data_hi  <= next_data_hi;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fuse and lock bytes

    always_comb
    begin
        next_fuse_low  = fuse_low;
        next_fuse_high = fuse_high;
        next_fuse_ext  = fuse_ext;
        next_lock      = lock;
        if (start_nv && cmd == ppl_pkg::CMD_WR_FUSE)
        begin
            if (sel == ppl_pkg::SEL_LOW)
                next_fuse_low = data_lo;                                            // [R10]
            else if (sel == ppl_pkg::SEL_HIGH)
                next_fuse_high = data_lo;                                           // [R11]
            else if (sel == ppl_pkg::SEL_EXT)
                next_fuse_ext = data_lo;                                            // [R12]
        end
        else if (start_nv)
        begin
            next_lock = lock_merge(lock, data_lo);                                  // [R13]
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fuse_low  <= ppl_pkg::FUSE_LOW_RST;
            fuse_high <= ppl_pkg::FUSE_HIGH_RST;
            fuse_ext  <= ppl_pkg::FUSE_EXT_RST;
            lock      <= ppl_pkg::LOCK_RST;
        end
        else
        begin
            fuse_low  <= next_fuse_low;
            fuse_high <= next_fuse_high;
            fuse_ext  <= next_fuse_ext;
            lock      <= next_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write sequencing: page copy runs under the busy timer

    always_comb
    begin
        next_state    = state;
        next_copy_cnt = copy_cnt;
        next_busy_cnt = busy_cnt;
        next_copy_ee  = copy_ee;
        case (state)
            ppl_pkg::PPL_IDLE:
            begin
                next_copy_cnt = '0;
                next_busy_cnt = '0;
                if (start_page)
                begin
                    next_state   = ppl_pkg::PPL_COPY;                                // [R3] [R7]
                    next_copy_ee = (cmd == ppl_pkg::CMD_WR_EE);
                end
                else if (start_nv)
                begin
                    next_state = ppl_pkg::PPL_WAIT;                                  // [R10] [R13]
                end
            end
            ppl_pkg::PPL_COPY:
            begin
                next_busy_cnt = sat_inc(busy_cnt);
                next_copy_cnt = copy_cnt + 1'b1;
                if (copy_cnt == copy_limit)
                    next_state = ppl_pkg::PPL_WAIT;
            end
            ppl_pkg::PPL_WAIT:
            begin
                next_busy_cnt = sat_inc(busy_cnt);
                if (busy_cnt == BUSY_LAST)
                    next_state = ppl_pkg::PPL_IDLE;                                  // [R23]
            end
            default:
            begin
                next_state = ppl_pkg::PPL_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state    <= ppl_pkg::PPL_IDLE;
            copy_cnt <= '0;
            busy_cnt <= '0;
            copy_ee  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            copy_cnt <= next_copy_cnt;
            busy_cnt <= next_busy_cnt;
            copy_ee  <= next_copy_ee;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    always_comb
    begin
        next_data_out = ppl_pkg::DATA_IDLE;
        next_data_oe  = !output_enable_n;                                            // [R22]
        if (cmd == ppl_pkg::CMD_RD_FLASH)
        begin
            next_data_out = pick_byte(flash_rdata, byte_select_one);                 // [R8]
        end
        else if (cmd == ppl_pkg::CMD_RD_EE && !byte_select_one)
        begin
            next_data_out = ee_rdata;                                                // [R9]
        end
        else if (cmd == ppl_pkg::CMD_RD_FUSE)
        begin
            if (sel == ppl_pkg::SEL_RD_FLOW)
                next_data_out = fuse_low;                                            // [R16]
            else if (sel == ppl_pkg::SEL_RD_FHI)
                next_data_out = fuse_high;                                           // [R16]
            else if (sel == ppl_pkg::SEL_RD_FEXT)
                next_data_out = fuse_ext;                                            // [R16]
            else
                next_data_out = lock;                                                // [R16]
        end
        else if (cmd == ppl_pkg::CMD_RD_SIG && !byte_select_one)
        begin
            if (addr_lo == ppl_pkg::CAL_ADDR)
                next_data_out = ID_BYTE0;                                            // [R17]
            else if (addr_lo < ppl_pkg::SIG_ADDR_MAX)
                next_data_out = ID_BYTE1;                                            // [R17]
            else if (addr_lo == ppl_pkg::SIG_ADDR_MAX)
                next_data_out = ID_BYTE2;                                            // [R17]
        end
        else if (cmd == ppl_pkg::CMD_RD_SIG && addr_lo == ppl_pkg::CAL_ADDR)
        begin
            next_data_out = CAL_BYTE;                                                // [R18]
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_out <= ppl_pkg::DATA_IDLE;
            data_oe  <= 1'b0;
        end
        else
        begin
            data_out <= next_data_out;
            data_oe  <= next_data_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page buffers and arrays

    assign fbuf_we     = latch_evt && (cmd == ppl_pkg::CMD_WR_FLASH);                // [R21]
    assign ebuf_we     = latch_evt && (cmd == ppl_pkg::CMD_WR_EE);                   // [R21]
    assign fbuf_raddr  = copy_cnt[FPAGE_AW-1:0];
    assign ebuf_raddr  = copy_cnt[EPAGE_AW-1:0];
    // Buffer read data lags its address by one, so writes trail the count by one
    assign flash_we    = (state == ppl_pkg::PPL_COPY) && !copy_ee && (copy_cnt != '0);
    assign ee_we       = (state == ppl_pkg::PPL_COPY) && copy_ee && (copy_cnt != '0);
    assign flash_waddr = {full_addr[FLASH_AW-1:FPAGE_AW], copy_idx[FPAGE_AW-1:0]};
    assign ee_waddr    = {full_addr[EE_AW-1:EPAGE_AW], copy_idx[EPAGE_AW-1:0]};

    ppl_mem #(.DW(16), .AW(FPAGE_AW)) u_flash_buf (
        .core_clk (core_clk), .nrst (nrst),
        .we (fbuf_we), .waddr (addr_lo[FPAGE_AW-1:0]), .wdata ({data_hi, data_lo}),
        .raddr (fbuf_raddr), .rdata (fbuf_rdata)
    );

    ppl_mem #(.DW(8), .AW(EPAGE_AW)) u_ee_buf (
        .core_clk (core_clk), .nrst (nrst),
        .we (ebuf_we), .waddr (addr_lo[EPAGE_AW-1:0]), .wdata (data_lo),
        .raddr (ebuf_raddr), .rdata (ebuf_rdata)
    );

    ppl_mem #(.DW(16), .AW(FLASH_AW)) u_flash (
        .core_clk (core_clk), .nrst (nrst),
        .we (flash_we), .waddr (flash_waddr), .wdata (fbuf_rdata),
        .raddr (full_addr[FLASH_AW-1:0]), .rdata (flash_rdata)
    );

    ppl_mem #(.DW(8), .AW(EE_AW)) u_ee (
        .core_clk (core_clk), .nrst (nrst),
        .we (ee_we), .waddr (ee_waddr), .wdata (ebuf_rdata),
        .raddr (full_addr[EE_AW-1:0]), .rdata (ee_rdata)
    );

endmodule

// file: common/ppl_pkg.sv
// Shared constants and types for the parallel program loader
package ppl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Action select codes sampled on a load strobe rising edge
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // Byte select codes {byte_select_two, byte_select_one}
    localparam logic [1:0] SEL_LOW     = 2'h0;
    localparam logic [1:0] SEL_HIGH    = 2'h1;
    localparam logic [1:0] SEL_EXT     = 2'h2;
    localparam logic [1:0] SEL_RD_FLOW = 2'h0;
    localparam logic [1:0] SEL_RD_LOCK = 2'h1;
    localparam logic [1:0] SEL_RD_FEXT = 2'h2;
    localparam logic [1:0] SEL_RD_FHI  = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Command bytes
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE    = 8'h11;
    localparam logic [7:0] CMD_RD_SIG   = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE    = 8'h03;

    ////////////////////////////////////////////////////////////////////////////
    // Lock byte layout, zero means programmed
    localparam int         LOCK_FIRST_BIT  = 0;
    localparam int         LOCK_SECOND_BIT = 1;
    localparam logic [7:0] LOCK_BOOT_MASK  = 8'h3c;
    localparam logic [1:0] LOCK_MODE3      = 2'h0;

    // Reset contents of the nonvolatile bytes (erased)
    localparam logic [7:0] FUSE_LOW_RST  = 8'hff;
    localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST  = 8'hff;
    localparam logic [7:0] LOCK_RST      = 8'hff;

    // Identification and calibration addresses
    localparam logic [7:0] SIG_ADDR_MAX = 8'h02;
    localparam logic [7:0] CAL_ADDR     = 8'h00;
    localparam logic [7:0] DATA_IDLE    = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int FLASH_AW  = 16;
    localparam int FPAGE_AW  = 7;
    localparam int EE_AW     = 12;
    localparam int EPAGE_AW  = 3;

    // Timing: write strobe low to ready, least time
    localparam int CLK_FREQ_MHZ     = 200;
    localparam int T_WRITE_US       = 3700;
    localparam int WRITE_CYCLES     = T_WRITE_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {PPL_IDLE, PPL_COPY, PPL_WAIT} ppl_state_t;

endpackage

// file: logic/ppl_mem.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module ppl_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          nrst,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////////
    // Array has no reset; contents only change by write
    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule

// file: verif/ppl_loader_properties.sv
// Port checker for the loader
`timescale 1ns/1ps
module ppl_chk #(parameter int WRITE_CYCLES = 40) (
    input wire logic core_clk, nrst, load_strobe, action_select_hi, action_select_lo, byte_select_one,
    input wire logic byte_select_two, page_latch_strobe, write_n, output_enable_n, data_oe, ready_busy_flag,
    input wire logic [7:0] data_in, data_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    int cnt, next_cnt;
    always_comb next_cnt = ready_busy_flag ? 0 : cnt + 1;
    always_ff @(posedge core_clk or negedge nrst)
        if (!nrst) cnt <= 0;
        else cnt <= next_cnt;
    a_bus_release: assert property (output_enable_n [*3] |-> !data_oe) else $error("bus driven");
    a_bus_drive: assert property ((!output_enable_n) [*3] |-> data_oe) else $error("bus idle");
    a_busy_cause: assert property ($fell(ready_busy_flag) |->
        !($past(write_n) && $past(write_n, 2) && $past(write_n, 3))) else $error("busy uncaused");
    a_busy_hold: assert property ($fell(ready_busy_flag) |-> (!ready_busy_flag) [*8]) else $error("short");
    a_busy_max: assert property (cnt <= WRITE_CYCLES + 4) else $error("busy too long");
    a_busy_min: assert property ($rose(ready_busy_flag) |-> $past(cnt) >= WRITE_CYCLES - 4) else $error("early");
    a_ready_reset: assert property ($rose(nrst) |-> ready_busy_flag) else $error("busy at start");
    a_read_stable: assert property ($stable({load_strobe, page_latch_strobe, write_n,
        output_enable_n, byte_select_one, byte_select_two}) [*4] ##0 data_oe |-> $stable(data_out)) else $error("drift");
endmodule
bind ppl_loader ppl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.*);

// file: verif/ppl_prog.sv
// Programmer model driving the loader pins
`timescale 1ns/1ps
module ppl_prog (
    input wire logic clk, rdy,
    input wire logic [7:0] bus,
    output logic xs, ahi, alo, bs1, bs2, pl, wr_n, oe_n,
    output logic [7:0] dq
);
    initial {xs, ahi, alo, bs1, bs2, pl, wr_n, oe_n, dq} = {8'h03, 8'h00};
    task automatic ld(input logic [1:0] act, sel, input logic [7:0] d);
        @(negedge clk) {ahi, alo, bs2, bs1, dq} = {act, sel, d};
        @(negedge clk) xs = 1;
        repeat (2) @(negedge clk);
        xs = 0;
        repeat (2) @(negedge clk);
    endtask
    task automatic latch;
        @(negedge clk) bs1 = 1;
        @(negedge clk) pl = 1;
        repeat (2) @(negedge clk);
        pl = 0;
    endtask
    task automatic wr(input logic [1:0] sel);
        @(negedge clk) {bs2, bs1} = sel;
        @(negedge clk) wr_n = 0;
        repeat (2) @(negedge clk);
        wr_n = 1;
        for (int n = 0; n < 5000 && !rdy; n++) @(negedge clk);
        {bs2, bs1} = 2'h0;
    endtask
    // Bus released while reading, so the old value is inverted
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        @(negedge clk) {bs2, bs1, oe_n, dq} = {sel, 1'b0, ~dq};
        repeat (5) @(negedge clk);
        d = bus;
        oe_n = 1;
    endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the loader
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, nrst = 0, ls, ahi, alo, bs1, bs2, pl, wr_n, oe_n, oe, rdy;
    logic [7:0] dq, din, dout, v;
    int failures, n_compared, cyc;
    assign din = oe ? dout : dq;
    initial forever #2.5 core_clk = ~core_clk;
    // Busy time must exceed the 129-cycle flash page copy
    ppl_loader #(.WRITE_CYCLES(200), .ID_BYTE0(8'h61), .ID_BYTE1(8'h62), .ID_BYTE2(8'h63), .CAL_BYTE(8'h7e))
    u_ppl_loader (.core_clk, .nrst, .load_strobe(ls), .action_select_hi(ahi), .action_select_lo(alo),
        .byte_select_one(bs1), .byte_select_two(bs2), .page_latch_strobe(pl), .write_n(wr_n),
        .output_enable_n(oe_n), .data_in(din), .data_out(dout), .data_oe(oe), .ready_busy_flag(rdy));
    ppl_prog u_prog (.clk(core_clk), .rdy, .bus(din), .xs(ls), .ahi, .alo, .bs1, .bs2, .pl, .wr_n, .oe_n, .dq);
    task automatic rdc(string what, logic [1:0] sel, logic [7:0] exp);
        u_prog.rd(sel, v);
        n_compared++;
        if (v !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, v);
        end
    endtask
    task automatic t_mem;
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_WR_FLASH);
        u_prog.ld(2'h0, 2'h0, 8'h85);
        u_prog.ld(2'h1, 2'h0, 8'h12);
        u_prog.ld(2'h1, 2'h1, 8'h34);
        u_prog.latch();
        u_prog.ld(2'h0, 2'h1, 8'h01);
        u_prog.ld(2'h0, 2'h2, 8'h00);
        u_prog.wr(2'h0);
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_NOP);
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_RD_FLASH);
        rdc("flash low", 2'h0, 8'h12);
        rdc("flash high", 2'h1, 8'h34);
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_WR_EE);
        u_prog.ld(2'h0, 2'h1, 8'h00);
        u_prog.ld(2'h0, 2'h0, 8'h0a);
        u_prog.ld(2'h1, 2'h0, 8'h5e);
        u_prog.latch();
        u_prog.wr(2'h0);
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_RD_EE);
        rdc("eeprom", 2'h0, 8'h5e);
        $display("memory test done");
    endtask
    task automatic t_fuse;
        logic [7:0] wd[3] = '{8'hfc, 8'h00, 8'hff};
        logic [7:0] ex[3] = '{8'hfc, 8'h3c, 8'h3c};
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_WR_FUSE);
        for (int i = 0; i < 3; i++)
        begin
            u_prog.ld(2'h1, 2'h0, 8'ha0 + 8'(i));
            u_prog.wr(2'(i));
        end
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_RD_FUSE);
        rdc("fuse low", 2'h0, 8'ha0);
        rdc("fuse high", 2'h3, 8'ha1);
        rdc("fuse ext", 2'h2, 8'ha2);
        for (int i = 0; i < 3; i++)
        begin
            u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_WR_LOCK);
            u_prog.ld(2'h1, 2'h0, wd[i]);
            u_prog.wr(2'h0);
            u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_RD_FUSE);
            rdc("lock", 2'h1, ex[i]);
        end
        u_prog.ld(2'h2, 2'h0, ppl_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++)
        begin
            u_prog.ld(2'h0, 2'h0, 8'(i));
            rdc("id byte", 2'h0, 8'h61 + 8'(i));
        end
        u_prog.ld(2'h0, 2'h0, 8'h00);
        rdc("calibration", 2'h1, 8'h7e);
        $display("fuse lock id test done");
    endtask
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge core_clk);
        nrst = 1;
        t_mem();
        t_fuse();
        end_sim();
    end
    always @(posedge core_clk)
        if (++cyc > 20000)
        begin
            failures++;
            end_sim();
        end
endmodule
